// [verilog/serial_port_pkg.sv]
// How it works
// [RQ1] every register is one byte, bit7 msb
// [RQ2] decode base from switch plus offset
// [RQ3] offset 0 read pops oldest received char
// [RQ4] offset 0 write loads transmit holding
// [RQ5] access bit routes offsets 0,1 to divisor
// [RQ6] divisor bytes form one 16-bit rate divider
// [RQ7] software picks divisor inverse to bit rate
// [RQ8] line control: length, stop, parity, break, access
// [RQ9] modem control bit 1 drives rts
// [RQ10] line status 0-4: ready, overrun, parity, framing, break
// [RQ11] line status 5: transmit holding empty
// [RQ12] line status 6: shifter empty too
// [RQ13] line status 7: error char in fifo
// [RQ14] modem status deltas and present levels
// [RQ15] ring delta only on trailing edge
// [RQ16] offset 1 holds four interrupt enables
// [RQ17] fifo control: enable, clears, mode, trigger
// [RQ18] offset 7 is a plain scratch byte
`default_nettype none
package serial_port_pkg;
    localparam logic [2:0] off_data = 3'h0;
    localparam logic [2:0] off_enables = 3'h1;
    localparam logic [2:0] off_fifo_control = 3'h2;
    localparam logic [2:0] off_line_control = 3'h3;
    localparam logic [2:0] off_modem_control = 3'h4;
    localparam logic [2:0] off_line_status = 3'h5;
    localparam logic [2:0] off_modem_status = 3'h6;
    localparam logic [2:0] off_scratch = 3'h7;
    localparam logic [15:0] divisor_reset = 16'h0001;
    localparam logic [7:0] line_control_reset = 8'h03;
    localparam logic [7:0] byte_reset = 8'h00;
    localparam int fifo_depth = 16;
    localparam logic [3:0] sub_mid = 4'h7;
    localparam logic [3:0] sub_last = 4'hf;
    localparam logic [5:0] stop_one = 6'h0f;
    localparam logic [5:0] stop_one_half = 6'h17;
    localparam logic [5:0] stop_two = 6'h1f;
    localparam logic [4:0] trig_1 = 5'h01;
    localparam logic [4:0] trig_4 = 5'h04;
    localparam logic [4:0] trig_8 = 5'h08;
    localparam logic [4:0] trig_14 = 5'h0e;

    typedef struct packed {
        logic rd;
        logic wr;
        logic [9:0] addr;
        logic [7:0] wdata;
    } io_req_t;

    typedef struct packed {
        logic cts;
        logic dsr;
        logic ri;
        logic dcd;
    } modem_in_t;

    typedef struct packed {
        logic bi;
        logic fe;
        logic pe;
        logic [7:0] data;
    } rx_entry_t;
endpackage : serial_port_pkg
`default_nettype wire

// [verilog/async_serial_port_regs.sv]
`timescale 1ns/1ps
`default_nettype none
module async_serial_port_regs import serial_port_pkg::*; (
    input wire logic mclk,
    input wire logic resetn,
    input wire io_req_t io,
    input wire logic [6:0] port_one_base_switch,
    output logic [7:0] rdata,
    input wire logic serial_in,
    output logic serial_out,
    input wire modem_in_t modem,
    output logic rts,
    output logic receive_ready_signal,
    output logic transmit_ready_signal
);
    typedef enum {st_idle, st_start, st_data, st_par, st_stop} line_state_t;

    // ****************************************
    // registers and decode
    // ****************************************
    logic [15:0] divisor;
    logic [7:0] line_control, modem_control, interrupt_enables, scratch_byte;
    logic fifo_en, rdy_mode, overrun;
    logic [1:0] trig_sel;
    logic [3:0] msr_delta;
    modem_in_t modem_q;
    logic hit, wr, rd, divisor_access_bit, clr_rx, clr_tx;
    logic [2:0] off;

    assign hit = io.addr[9:3] == port_one_base_switch; // [RQ2]
    assign off = io.addr[2:0];
    assign wr = io.wr && hit;
    assign rd = io.rd && hit;
    assign divisor_access_bit = line_control[7]; // [RQ8]
    assign clr_rx = wr && off == off_fifo_control && (io.wdata[1] || io.wdata[0] != fifo_en);
    assign clr_tx = wr && off == off_fifo_control && (io.wdata[2] || io.wdata[0] != fifo_en);

    function automatic logic [4:0] trig_level(input logic [1:0] sel);
        unique case (sel)
            2'h0: trig_level = trig_1;
            2'h1: trig_level = trig_4;
            2'h2: trig_level = trig_8;
            2'h3: trig_level = trig_14;
        endcase
    endfunction : trig_level

    // expected parity for len data bits under the current line control
    function automatic logic parity_of(input logic [7:0] d, input logic [7:0] lc);
        logic [7:0] m;
        m = d & (8'hff >> (3'h3 - lc[1:0]));
        if (lc[5])
            parity_of = !lc[4];
        else
            parity_of = lc[4] ? ^m : ~^m;
    endfunction : parity_of

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            divisor <= divisor_reset;
            line_control <= line_control_reset;
            modem_control <= byte_reset;
            interrupt_enables <= byte_reset;
            scratch_byte <= byte_reset;
            fifo_en <= 1'b0;
            rdy_mode <= 1'b0;
            trig_sel <= 2'h0;
        end else if (wr) begin
            unique case (off)
                off_data: if (divisor_access_bit) divisor[7:0] <= io.wdata; // [RQ5]
                off_enables: begin
                    if (divisor_access_bit)
                        divisor[15:8] <= io.wdata; // [RQ5] [RQ6]
                    else
                        interrupt_enables <= {4'h0, io.wdata[3:0]}; // [RQ16]
                end
                off_fifo_control: begin
                    fifo_en <= io.wdata[0]; // [RQ17]
                    rdy_mode <= io.wdata[3];
                    trig_sel <= io.wdata[7:6];
                end
                off_line_control: line_control <= io.wdata; // [RQ8]
                off_modem_control: modem_control <= io.wdata;
                off_scratch: scratch_byte <= io.wdata; // [RQ18]
                default: ;
            endcase
        end
    end

    // ****************************************
    // baud tick: sixteen per bit
    // ****************************************
    logic [15:0] baud_cnt;
    logic tick;
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            baud_cnt <= 16'h0000;
            tick <= 1'b0;
        end else if (baud_cnt + 16'h0001 >= divisor) begin // [RQ6]
            baud_cnt <= 16'h0000;
            tick <= 1'b1;
        end else begin
            baud_cnt <= baud_cnt + 16'h0001;
            tick <= 1'b0;
        end
    end

    // ****************************************
    // fifos; depth one while fifos are off
    // ****************************************
    rx_entry_t rx_mem [fifo_depth];
    logic [7:0] tx_mem [fifo_depth];
    logic [3:0] rx_wr, rx_rd, tx_wr, tx_rd;
    logic [4:0] rx_count, tx_count, depth, err_count;
    logic rx_push, rx_pop, tx_push, tx_pop, rx_full, tx_empty, tx_busy;
    rx_entry_t rx_new, rx_top;
    logic [7:0] rx_top_data;

    assign depth = fifo_en ? 5'(fifo_depth) : 5'h01;
    assign rx_full = rx_count >= depth;
    assign tx_empty = tx_count == 5'h00;
    assign rx_top = rx_mem[rx_rd];
    assign rx_top_data = rx_top.data;
    assign rx_pop = rd && off == off_data && !divisor_access_bit && rx_count != 5'h00; // [RQ3]
    assign tx_push = wr && off == off_data && !divisor_access_bit && tx_count < depth; // [RQ4]

    always_ff @(posedge mclk) begin
        if (rx_push && !rx_full)
            rx_mem[rx_wr] <= rx_new;
        if (tx_push)
            tx_mem[tx_wr] <= io.wdata;
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            rx_wr <= 4'h0;
            rx_rd <= 4'h0;
            rx_count <= 5'h00;
            err_count <= 5'h00;
        end else if (clr_rx) begin
            rx_wr <= 4'h0;
            rx_rd <= 4'h0;
            rx_count <= 5'h00;
            err_count <= 5'h00;
        end else begin
            if (rx_push && !rx_full)
                rx_wr <= rx_wr + 4'h1;
            if (rx_pop)
                rx_rd <= rx_rd + 4'h1;
            rx_count <= rx_count + 5'(rx_push && !rx_full) - 5'(rx_pop);
            err_count <= err_count + 5'(rx_push && !rx_full && (rx_new.pe | rx_new.fe | rx_new.bi))
                - 5'(rx_pop && (rx_top.pe | rx_top.fe | rx_top.bi)); // [RQ13]
        end
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            tx_wr <= 4'h0;
            tx_rd <= 4'h0;
            tx_count <= 5'h00;
        end else if (clr_tx) begin
            tx_wr <= 4'h0;
            tx_rd <= 4'h0;
            tx_count <= 5'h00;
        end else begin
            if (tx_push)
                tx_wr <= tx_wr + 4'h1;
            if (tx_pop)
                tx_rd <= tx_rd + 4'h1;
            tx_count <= tx_count + 5'(tx_push) - 5'(tx_pop);
        end
    end

    // ****************************************
    // receiver
    // ****************************************
    line_state_t rx_state;
    logic [3:0] rx_sub;
    logic [2:0] rx_bit;
    logic [7:0] rx_shift;
    logic rx_perr, rx_zero;
    assign rx_new = '{bi: rx_zero && !serial_in, fe: !serial_in, pe: rx_perr, data: rx_shift};
    assign rx_push = tick && rx_state == st_stop && rx_sub == sub_last;

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            rx_state <= st_idle;
            rx_sub <= 4'h0;
            rx_bit <= 3'h0;
            rx_shift <= 8'h00;
            rx_perr <= 1'b0;
            rx_zero <= 1'b0;
        end else if (tick) begin
            rx_sub <= rx_sub + 4'h1;
            unique case (rx_state)
                st_idle: begin
                    rx_sub <= 4'h0;
                    if (!serial_in) rx_state <= st_start;
                end
                st_start: if (rx_sub == sub_mid) begin
                    rx_sub <= 4'h0;
                    rx_bit <= 3'h0;
                    rx_shift <= 8'h00;
                    rx_perr <= 1'b0;
                    rx_zero <= 1'b1;
                    rx_state <= serial_in ? st_idle : st_data;
                end
                st_data: if (rx_sub == sub_last) begin
                    rx_shift[rx_bit] <= serial_in;
                    rx_zero <= rx_zero && !serial_in;
                    rx_bit <= rx_bit + 3'h1;
                    if (rx_bit == {1'b1, line_control[1:0]})
                        rx_state <= line_control[3] ? st_par : st_stop;
                end
                st_par: if (rx_sub == sub_last) begin
                    rx_perr <= serial_in != parity_of(rx_shift, line_control);
                    rx_zero <= rx_zero && !serial_in;
                    rx_state <= st_stop;
                end
                st_stop: if (rx_sub == sub_last) rx_state <= st_idle;
            endcase
        end
    end

    // ****************************************
    // transmitter
    // ****************************************
    line_state_t tx_state;
    logic [3:0] tx_sub;
    logic [5:0] tx_stop;
    logic [2:0] tx_bit;
    logic [7:0] tx_shift;
    logic tx_line;
    assign tx_pop = tick && tx_state == st_idle && !tx_empty && !clr_tx;
    assign tx_busy = tx_state != st_idle;

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            tx_state <= st_idle;
            tx_sub <= 4'h0;
            tx_stop <= 6'h00;
            tx_bit <= 3'h0;
            tx_shift <= 8'h00;
            tx_line <= 1'b1;
        end else if (tick) begin
            tx_sub <= tx_sub + 4'h1;
            unique case (tx_state)
                st_idle: begin
                    tx_line <= 1'b1;
                    tx_sub <= 4'h0;
                    if (tx_pop) begin
                        tx_shift <= tx_mem[tx_rd];
                        tx_line <= 1'b0;
                        tx_state <= st_start;
                    end
                end
                st_start: if (tx_sub == sub_last) begin
                    tx_bit <= 3'h0;
                    tx_line <= tx_shift[0];
                    tx_state <= st_data;
                end
                st_data: if (tx_sub == sub_last) begin
                    tx_bit <= tx_bit + 3'h1;
                    tx_line <= tx_shift[3'(tx_bit + 3'h1)];
                    if (tx_bit == {1'b1, line_control[1:0]}) begin
                        tx_line <= line_control[3] ? parity_of(tx_shift, line_control) : 1'b1;
                        tx_state <= line_control[3] ? st_par : st_stop;
                        tx_stop <= 6'h00;
                    end
                end
                st_par: if (tx_sub == sub_last) begin
                    tx_line <= 1'b1;
                    tx_stop <= 6'h00;
                    tx_state <= st_stop;
                end
                st_stop: begin
                    tx_stop <= tx_stop + 6'h01;
                    // 1.5 stop bits apply only to 5-bit characters
                    if (tx_stop == (!line_control[2] ? stop_one
                        : line_control[1:0] == 2'h0 ? stop_one_half : stop_two))
                        tx_state <= st_idle;
                end
            endcase
        end
    end

    // ****************************************
    // status, modem and read data
    // ****************************************
    logic [7:0] lsr_now, msr_now;
    assign lsr_now = {err_count != 5'h00, // [RQ13]
                      tx_empty && !tx_busy, // [RQ12]
                      tx_empty, // [RQ11]
                      rx_top.bi && rx_count != 5'h00,
                      rx_top.fe && rx_count != 5'h00,
                      rx_top.pe && rx_count != 5'h00,
                      overrun, rx_count != 5'h00}; // [RQ10]
    assign msr_now = {modem.dcd, modem.ri, modem.dsr, modem.cts, msr_delta}; // [RQ14]

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn)
            overrun <= 1'b0;
        else if (rx_push && rx_full && !clr_rx)
            overrun <= 1'b1; // set wins over the read clear
        else if (rd && off == off_line_status)
            overrun <= 1'b0;
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            modem_q <= '0;
            msr_delta <= 4'h0;
        end else begin
            modem_q <= modem;
            msr_delta <= ((rd && off == off_modem_status) ? 4'h0 : msr_delta)
                | {modem.dcd != modem_q.dcd, // [RQ14]
                   modem_q.ri && !modem.ri, // [RQ15]
                   modem.dsr != modem_q.dsr, modem.cts != modem_q.cts};
        end
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            rdata <= 8'h00;
        end else if (rd) begin
            unique case (off) // [RQ1]
                off_data: rdata <= divisor_access_bit ? divisor[7:0] : rx_top_data; // [RQ3] [RQ5]
                off_enables: rdata <= divisor_access_bit ? divisor[15:8] : interrupt_enables;
                off_fifo_control: rdata <= 8'h00;
                off_line_control: rdata <= line_control;
                off_modem_control: rdata <= modem_control;
                off_line_status: rdata <= lsr_now;
                off_modem_status: rdata <= msr_now;
                off_scratch: rdata <= scratch_byte;
            endcase
        end
    end

    // pins: break holds the line low regardless of the shifter
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            serial_out <= 1'b1;
            rts <= 1'b0;
            receive_ready_signal <= 1'b0;
            transmit_ready_signal <= 1'b0;
        end else begin
            serial_out <= line_control[6] ? 1'b0 : tx_line; // [RQ8]
            rts <= modem_control[1]; // [RQ9]
            receive_ready_signal <= rdy_mode ? rx_count >= trig_level(trig_sel)
                : rx_count != 5'h00; // [RQ17]
            transmit_ready_signal <= rdy_mode ? tx_count < depth : tx_empty;
        end
    end

    // ****************************************
    // assertions
    // ****************************************
    property p_rts;
        @(posedge mclk) disable iff (!resetn)
        (wr && off == off_modem_control) |-> ##2 rts == $past(io.wdata[1], 2);
    endproperty
    a_rts: assert property (p_rts) else $error("rts does not follow modem control"); // [RQ9]
    property p_rx_read;
        @(posedge mclk) disable iff (!resetn)
        rx_pop |=> rdata == $past(rx_top_data);
    endproperty
    a_rx_read: assert property (p_rx_read) else $error("wrong received byte"); // [RQ3]
    property p_tx_load;
        @(posedge mclk) disable iff (!resetn)
        (tx_push && tx_empty && !tx_pop && !clr_tx) |=> tx_count == 5'h01 && !lsr_now[5];
    endproperty
    a_tx_load: assert property (p_tx_load) else $error("holding write lost"); // [RQ4]
    property p_div_low;
        @(posedge mclk) disable iff (!resetn)
        (wr && off == off_data && divisor_access_bit) |=> divisor[7:0] == $past(io.wdata)
            && tx_count == $past(tx_count) - 5'($past(tx_pop));
    endproperty
    a_div_low: assert property (p_div_low) else $error("divisor low byte write wrong"); // [RQ5]
    property p_thre;
        @(posedge mclk) disable iff (!resetn)
        (rd && off == off_line_status) |=> rdata[5] == $past(tx_empty)
            && rdata[0] == $past(rx_count != 5'h00);
    endproperty
    a_thre: assert property (p_thre) else $error("line status bits wrong"); // [RQ11] [RQ10]
    property p_temt;
        @(posedge mclk) disable iff (!resetn)
        lsr_now[6] |-> tx_line;
    endproperty
    a_temt: assert property (p_temt) else $error("shifter empty while line not idle"); // [RQ12]
    property p_ring;
        @(posedge mclk) disable iff (!resetn)
        (modem_q.ri != modem.ri && !msr_delta[2]) |=> msr_delta[2] == $past(modem_q.ri);
    endproperty
    a_ring: assert property (p_ring) else $error("ring trailing edge missed"); // [RQ15]
    property p_break;
        @(posedge mclk) disable iff (!resetn)
        line_control[6] [*2] |-> !serial_out;
    endproperty
    a_break: assert property (p_break) else $error("break not driven"); // [RQ8]
    c_rx: cover property (@(posedge mclk) disable iff (!resetn) rx_push && !rx_full);
    c_tx: cover property (@(posedge mclk) disable iff (!resetn) tx_pop);
    c_overrun: cover property (@(posedge mclk) disable iff (!resetn) rx_push && rx_full);
endmodule : async_serial_port_regs
`default_nettype wire

// [verification/serial_line_model.sv]
`timescale 1ns/1ps
`default_nettype none
module serial_line_model (
    input wire logic mclk,
    input wire logic serial_out,
    output logic serial_in
);
    // ********************************
    // far end of the serial line
    // ********************************
    int bit_cycles = 16;

    initial begin
        serial_in = 1'b1;
    end

    // bits go out lsb first with the start bit at bit 0; one idle bit follows
    task automatic send_frame(input logic [11:0] bits, input int n);
        for (int i = 0; i < n; i++) begin
            serial_in <= bits[i];
            repeat (bit_cycles) @(negedge mclk);
        end
        serial_in <= 1'b1;
        repeat (bit_cycles) @(negedge mclk);
    endtask : send_frame

    // samples mid-bit so a one-tick launch skew still lands inside the bit
    task automatic get_char(input int nbits, output logic [7:0] d, output bit ok);
        int w;
        d = 8'h00;
        w = 0;
        while (serial_out !== 1'b0 && w < 2000) begin
            @(negedge mclk);
            w++;
        end
        ok = (w < 2000);
        repeat (bit_cycles / 2) @(negedge mclk);
        ok = ok && (serial_out === 1'b0);
        for (int i = 0; i < nbits; i++) begin
            repeat (bit_cycles) @(negedge mclk);
            d[i] = serial_out;
        end
        repeat (bit_cycles) @(negedge mclk);
        ok = ok && (serial_out === 1'b1);
    endtask : get_char
endmodule : serial_line_model
`default_nettype wire

// [verification/tb_async_serial_port_regs.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_async_serial_port_regs import serial_port_pkg::*;;
    logic mclk;
    logic resetn;
    io_req_t io;
    logic [7:0] rdata;
    logic serial_in;
    logic serial_out;
    logic rts;
    logic rx_rdy;
    logic tx_rdy;
    modem_in_t modem;
    logic [6:0] sel;
    logic [6:0] sw;
    logic [7:0] got;
    logic [7:0] txd;
    bit ok;
    int fail_count;
    int compares;
    logic [7:0] rst_val [8] = '{8'h00, 8'h00, 8'h00, 8'h03, 8'h00, 8'h60, 8'h00, 8'h00};
    logic [3:0] mod_lv [6] = '{4'b1000, 4'b1100, 4'b1101, 4'b1111, 4'b1101, 4'b1101};
    logic [7:0] msr_exp [6] = '{8'h11, 8'h32, 8'hb8, 8'hf0, 8'hb4, 8'hb0};

    async_serial_port_regs async_serial_port_regs_i (
        .mclk(mclk), .resetn(resetn), .io(io), .port_one_base_switch(sw),
        .rdata(rdata), .serial_in(serial_in), .serial_out(serial_out),
        .modem(modem), .rts(rts), .receive_ready_signal(rx_rdy),
        .transmit_ready_signal(tx_rdy)
    );
    serial_line_model serial_line_model_i (
        .mclk(mclk), .serial_out(serial_out), .serial_in(serial_in)
    );

    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end

    // ********************************
    // bus access and checking
    // ********************************
    task automatic check_byte(input logic [7:0] g, input logic [7:0] e);
        compares++;
        if (g !== e) begin
            fail_count++;
            $display("wrong value at %0t ns: got %h expected %h", $time, g, e);
        end
    endtask : check_byte

    // an idle cycle follows each access so a strobe is never re-driven in one step
    task automatic acc(input logic w, input logic [2:0] off, input logic [7:0] d);
        io <= '{rd: !w, wr: w, addr: {sel, off}, wdata: d};
        @(negedge mclk);
        io.rd <= 1'b0;
        io.wr <= 1'b0;
        got = rdata;
        @(negedge mclk);
    endtask : acc

    task automatic rd_chk(input logic [2:0] off, input logic [7:0] e);
        acc(1'b0, off, 8'h00);
        check_byte(got, e);
    endtask : rd_chk

    task automatic rx8(input logic [7:0] d);
        serial_line_model_i.send_frame({3'b111, d, 1'b0}, 10);
    endtask : rx8

    task automatic end_test(input string s);
        $display("test %s finished, mismatches so far %0d", s, fail_count);
    endtask : end_test

    task automatic complete_run();
        $display("comparisons %0d, mismatches %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : complete_run

    initial begin
        #(20000 * 20);
        fail_count++;
        complete_run();
    end

    // ********************************
    // tests
    // ********************************
    initial begin
        io = '0;
        modem = '0;
        resetn = 1'b0;
        sel = 7'h7f;
        sw = 7'h7f;
        fail_count = 0;
        compares = 0;
        repeat (16) @(negedge mclk);
        resetn = 1'b1;
        @(negedge mclk);
        for (int i = 1; i < 8; i++) begin
            rd_chk(3'(i), rst_val[i]);
        end
        check_byte({7'h0, tx_rdy}, 8'h01);
        end_test("reset");
        acc(1'b1, off_line_control, 8'h80);
        rd_chk(off_data, 8'h01);
        acc(1'b1, off_data, 8'h34);
        acc(1'b1, off_enables, 8'h12);
        rd_chk(off_data, 8'h34);
        rd_chk(off_enables, 8'h12);
        acc(1'b1, off_data, 8'h01);
        acc(1'b1, off_enables, 8'h00);
        acc(1'b1, off_line_control, 8'h03);
        rd_chk(off_enables, 8'h00);
        acc(1'b1, off_enables, 8'h0f);
        rd_chk(off_enables, 8'h0f);
        acc(1'b1, off_scratch, 8'ha5);
        rd_chk(off_scratch, 8'ha5);
        sel = 7'h5f;
        acc(1'b1, off_scratch, 8'h3c);
        acc(1'b0, off_line_control, 8'h00);
        check_byte(got, 8'ha5);
        sw <= 7'h5f;
        acc(1'b1, off_scratch, 8'h5a);
        rd_chk(off_scratch, 8'h5a);
        sw <= 7'h7f;
        sel = 7'h7f;
        rd_chk(off_scratch, 8'h5a);
        acc(1'b1, off_modem_control, 8'h02);
        check_byte({7'h0, rts}, 8'h01);
        rd_chk(off_modem_control, 8'h02);
        acc(1'b1, off_modem_control, 8'h00);
        check_byte({7'h0, rts}, 8'h00);
        acc(1'b1, off_line_control, 8'h43);
        check_byte({7'h0, serial_out}, 8'h00);
        acc(1'b1, off_line_control, 8'h03);
        check_byte({7'h0, serial_out}, 8'h01);
        end_test("registers");
        for (int n = 0; n < 4; n++) begin
            acc(1'b1, off_line_control, 8'(n));
            fork
                serial_line_model_i.get_char(5 + n, txd, ok);
                begin
                    acc(1'b1, off_data, 8'hb5);
                    acc(1'b0, off_line_status, 8'h00);
                    check_byte({7'h0, got[6]}, 8'h00);
                end
            join
            check_byte(txd, 8'hb5 & (8'hff >> (3 - n)));
            check_byte({7'h0, ok}, 8'h01);
        end
        repeat (40) @(negedge mclk);
        rd_chk(off_line_status, 8'h60);
        // divisor 2 doubles every bit; the model follows by software choice
        acc(1'b1, off_line_control, 8'h83);
        acc(1'b1, off_data, 8'h02);
        acc(1'b1, off_line_control, 8'h03);
        serial_line_model_i.bit_cycles = 32;
        fork
            serial_line_model_i.get_char(8, txd, ok);
            acc(1'b1, off_data, 8'h3c);
        join
        check_byte(txd, 8'h3c);
        check_byte({7'h0, ok}, 8'h01);
        repeat (40) @(negedge mclk);
        acc(1'b1, off_line_control, 8'h83);
        acc(1'b1, off_data, 8'h01);
        acc(1'b1, off_line_control, 8'h03);
        serial_line_model_i.bit_cycles = 16;
        // seven bits, even parity, two stops: parity lands where bit 7 is read
        acc(1'b1, off_line_control, 8'h1e);
        fork
            serial_line_model_i.get_char(8, txd, ok);
            acc(1'b1, off_data, 8'h07);
        join
        check_byte(txd, 8'h87);
        check_byte({7'h0, ok}, 8'h01);
        repeat (12) @(negedge mclk);
        rd_chk(off_line_status, 8'h20);
        repeat (40) @(negedge mclk);
        acc(1'b1, off_line_control, 8'h03);
        end_test("transmit");
        rx8(8'h5a);
        rd_chk(off_line_status, 8'h61);
        rd_chk(off_data, 8'h5a);
        rd_chk(off_line_status, 8'h60);
        rx8(8'h11);
        rx8(8'h22);
        rd_chk(off_line_status, 8'h63);
        rd_chk(off_data, 8'h11);
        rd_chk(off_line_status, 8'h60);
        serial_line_model_i.send_frame(12'h000, 10);
        rd_chk(off_line_status, 8'hf9);
        rd_chk(off_data, 8'h00);
        rd_chk(off_line_status, 8'h60);
        acc(1'b1, off_line_control, 8'h1b);
        serial_line_model_i.send_frame({3'b110, 8'h01, 1'b0}, 11);
        rd_chk(off_line_status, 8'he5);
        rd_chk(off_data, 8'h01);
        acc(1'b1, off_line_control, 8'h03);
        end_test("receive");
        acc(1'b1, off_fifo_control, 8'h49);
        for (int i = 0; i < 4; i++) begin
            rx8(8'(8'h40 + i));
            check_byte({7'h0, rx_rdy}, {7'h0, i == 3});
        end
        for (int i = 0; i < 4; i++) begin
            rd_chk(off_data, 8'(8'h40 + i));
        end
        rx8(8'h77);
        acc(1'b1, off_fifo_control, 8'h4b);
        rd_chk(off_line_status, 8'h60);
        acc(1'b1, off_fifo_control, 8'h00);
        end_test("fifo");
        for (int i = 0; i < 6; i++) begin
            modem <= modem_in_t'(mod_lv[i]);
            repeat (4) @(negedge mclk);
            rd_chk(off_modem_status, msr_exp[i]);
        end
        end_test("modem");
        complete_run();
    end
endmodule : tb_async_serial_port_regs
`default_nettype wire
